// File: verilog/dipc_pkg.sv
// Package for the dual-issue pipeline control block.
// Assumes the fetch unit presents two adjacent pre-classified instructions.
package dipc_pkg;

	// ********************************************
	// Instruction groups and timing classes
	// ********************************************
	typedef enum logic [2:0] {
		DIPC_GRP_INTEGER_EXEC = 3'h0,
		DIPC_GRP_MOVE_TYPE    = 3'h1,
		DIPC_GRP_BRANCH       = 3'h2,
		DIPC_GRP_LOAD_STORE   = 3'h3,
		DIPC_GRP_FP_EXEC      = 3'h4,
		DIPC_GRP_EXCLUSIVE    = 3'h5
	} dipc_group_t;

	typedef enum logic [4:0] {
		DIPC_CLS_SIMPLE       = 5'h00,
		DIPC_CLS_BRANCH_DISP  = 5'h01,
		DIPC_CLS_BRANCH_REG   = 5'h02,
		DIPC_CLS_SUB_RETURN   = 5'h03,
		DIPC_CLS_EXC_RETURN   = 5'h04,
		DIPC_CLS_SOFT_TRAP    = 5'h05,
		DIPC_CLS_SLEEP        = 5'h06,
		DIPC_CLS_GBR_RMW      = 5'h07,
		DIPC_CLS_TEST_SET     = 5'h08,
		DIPC_CLS_ICACHE_BLOCK_INVALIDATE         = 5'h09,
		DIPC_CLS_INSTRUCTION_BLOCK_PREFETCH        = 5'h0a,
		DIPC_CLS_UNALIGNED    = 5'h0b,
		DIPC_CLS_LDC_SR_REG   = 5'h0c,
		DIPC_CLS_LDC_SR_MEM   = 5'h0d,
		DIPC_CLS_LDC_DBR_SGR  = 5'h0e,
		DIPC_CLS_MAC          = 5'h0f,
		DIPC_CLS_STC_SR       = 5'h10
	} dipc_class_t;

	typedef enum logic [3:0] {
		DIPC_ST_RUN    = 4'b0001,
		DIPC_ST_ISSUE  = 4'b0010,
		DIPC_ST_EXTRA  = 4'b0100,
		DIPC_ST_BRANCH = 4'b1000
	} dipc_state_t;

	// ********************************************
	// Counts and layout
	// ********************************************
	localparam int DIPC_NUM_STAGES    = 8;
	localparam int DIPC_PAGE_LSB      = 10;
	localparam logic [3:0] DIPC_CNT_BR_DISP_MAX = 4'h3;
	localparam logic [3:0] DIPC_CNT_BR_REG      = 4'h4;
	localparam logic [3:0] DIPC_CNT_RTS_MAX     = 4'h4;
	localparam logic [3:0] DIPC_CNT_RTE_ISSUE   = 4'h4;
	localparam logic [3:0] DIPC_CNT_RTE_BRANCH  = 4'h2;
	localparam logic [3:0] DIPC_CNT_TRAP_ISSUE  = 4'h8;
	localparam logic [3:0] DIPC_CNT_TRAP_EXTRA  = 4'h5;
	localparam logic [3:0] DIPC_CNT_TRAP_BRANCH = 4'h2;
	localparam logic [3:0] DIPC_CNT_SLEEP       = 4'h2;
	localparam logic [3:0] DIPC_CNT_GBR_RMW     = 4'h3;
	localparam logic [3:0] DIPC_CNT_TEST_SET    = 4'h4;
	localparam logic [3:0] DIPC_CNT_ICACHE_BLOCK_INVALIDATE_ISSUE  = 4'h8;
	localparam logic [3:0] DIPC_CNT_INSTRUCTION_BLOCK_PREFETCH_ISSUE = 4'h5;
	localparam logic [3:0] DIPC_CNT_CACHE_EXTRA = 4'h5;
	localparam logic [3:0] DIPC_CNT_CACHE_BR    = 4'h4;
	localparam logic [3:0] DIPC_CNT_UNALIGNED   = 4'h2;
	localparam logic [3:0] DIPC_CNT_LDC_SR_REG  = 4'h4;
	localparam logic [3:0] DIPC_CNT_LDC_SR_MEM  = 4'h6;
	localparam logic [3:0] DIPC_CNT_SR_BRANCH   = 4'h4;
	localparam logic [3:0] DIPC_CNT_LDC_CTRL    = 4'h4;
	localparam logic [3:0] DIPC_CNT_MAC         = 4'h2;
	localparam logic [3:0] DIPC_CNT_ONE         = 4'h1;
	localparam logic [3:0] DIPC_CNT_ZERO        = 4'h0;
	localparam logic [1:0] DIPC_PR_E3_DELAY     = 2'h3;

endpackage

// File: verilog/dipc_issue_ctrl.sv
// Issue and pipeline-timing control for a two-way in-order core.
// Assumes fetch presents two adjacent classified instructions and
// that the register file reports hazards against in-flight producers.
//
// Behaviour
// RQ1 - Two instructions may issue per cycle.
// RQ2 - Eight in-order stages per instruction.
// RQ3 - Displacement branches: one issue, zero-three branch cycles.
// RQ4 - Register branches: one issue, four branch cycles.
// RQ5 - Subroutine return: one issue, zero-four branch.
// RQ6 - Exception return: four issue, two branch.
// RQ7 - Trap: eight, five, two; handler decode fifteen.
// RQ8 - Sleep takes two issue cycles.
// RQ9 - Integer ops occupy only integer pipe.
// RQ10 - Moves use whichever pipe is free; the code places only a lead move, and a paired follower move sets no pipe busy.
// RQ11 - Byte RMW three cycles; test-and-set four.
// RQ12 - Cache invalidate 8+5+4; block prefetch 5+5+4.
// RQ13 - Unaligned longword load takes two cycles.
// RQ14 - Status load: 4+4 register, 6+4 memory.
// RQ15 - Debug or saved-stack load: four cycles.
// RQ16 - Status store occupies both the integer and load-store pipes.
// RQ17 - Return register updates in delay-slot E3.
// RQ18 - Multiply-accumulate takes two issue cycles.
// RQ19 - Every instruction belongs to one of six groups.
// RQ20 - Pair only within same 1 KB page.
// RQ21 - Pair only without in-flight data conflicts.
// RQ22 - Integer add pairs with unconditional branch.
// RQ23 - Same group never pairs except move-type; move-type pairs broadly.
// RQ24 - Failed pairing issues follower alone later.
// RQ25 - Data conflict locks decode until available.
`timescale 1ns/1ps
`default_nettype none

module dipc_issue_ctrl #(
	parameter int ADDR_W = 32
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire logic                  lead_valid,
	input  wire logic [ADDR_W-1:0]     lead_addr,
	input  wire dipc_pkg::dipc_group_t lead_group,
	input  wire dipc_pkg::dipc_class_t lead_class,
	input  wire logic                  lead_conflict,
	input  wire logic                  lead_prefetched,
	input  wire logic                  lead_pr_set,
	input  wire logic                  follow_valid,
	input  wire logic [ADDR_W-1:0]     follow_addr,
	input  wire dipc_pkg::dipc_group_t follow_group,
	input  wire logic                  follow_conflict,
	input  wire logic                  follow_pr_read,
	output logic                       issue_lead,
	output logic                       issue_follow,
	output logic                       id_locked,
	output logic                       pipe_int_busy,
	output logic                       pipe_ls_busy,
	output logic [7:0]                 stage_valid,
	output logic                       pr_bypass
);

	// ********************************************
	// State
	// ********************************************
	typedef struct packed {
		dipc_pkg::dipc_state_t state;
		logic [3:0]            cnt;
		logic [3:0]            extra;
		logic [3:0]            branch;
		logic [7:0]            stages;
		logic                  int_busy;
		logic                  ls_busy;
		logic [1:0]            pr_cnt;
		logic                  pr_wait;
	} dipc_regs_t;

	dipc_regs_t r;
	dipc_regs_t next_r;

	logic same_page;
	logic group_ok;
	logic can_pair;
	logic lead_go;
	logic [3:0] iss_n;
	logic [3:0] ext_n;
	logic [3:0] br_n;
	logic uses_int;
	logic uses_ls;

	// ********************************************
	// Pairing decision
	// ********************************************
	assign same_page = lead_addr[ADDR_W-1:dipc_pkg::DIPC_PAGE_LSB] ==
		follow_addr[ADDR_W-1:dipc_pkg::DIPC_PAGE_LSB]; // RQ20

	always_comb begin
		group_ok = 1'b1;
		if (lead_group == dipc_pkg::DIPC_GRP_EXCLUSIVE ||
			follow_group == dipc_pkg::DIPC_GRP_EXCLUSIVE) begin
			group_ok = 1'b0; // RQ23
		end else if (lead_group == dipc_pkg::DIPC_GRP_MOVE_TYPE ||
			follow_group == dipc_pkg::DIPC_GRP_MOVE_TYPE) begin
			group_ok = 1'b1; // RQ23
		end else if (lead_group == follow_group) begin
			group_ok = 1'b0; // RQ23 RQ19
		end
	end

	// Integer-exec lead with branch follower falls through as legal. RQ22
	assign lead_go  = r.state == dipc_pkg::DIPC_ST_RUN && lead_valid && !lead_conflict; // RQ25
	assign can_pair = lead_go && follow_valid && same_page && group_ok &&
		!follow_conflict && iss_n == dipc_pkg::DIPC_CNT_ONE &&
		br_n == dipc_pkg::DIPC_CNT_ZERO; // RQ21 RQ1 RQ24

	// ********************************************
	// Class timing table
	// ********************************************
	always_comb begin
		iss_n = dipc_pkg::DIPC_CNT_ONE;
		ext_n = dipc_pkg::DIPC_CNT_ZERO;
		br_n  = dipc_pkg::DIPC_CNT_ZERO;
		case (lead_class)
			dipc_pkg::DIPC_CLS_BRANCH_DISP: begin
				br_n = lead_prefetched ? dipc_pkg::DIPC_CNT_ZERO
					: dipc_pkg::DIPC_CNT_BR_DISP_MAX; // RQ3
			end
			dipc_pkg::DIPC_CLS_BRANCH_REG: begin
				br_n = dipc_pkg::DIPC_CNT_BR_REG; // RQ4
			end
			dipc_pkg::DIPC_CLS_SUB_RETURN: begin
				br_n = lead_prefetched ? dipc_pkg::DIPC_CNT_ZERO
					: dipc_pkg::DIPC_CNT_RTS_MAX; // RQ5
			end
			dipc_pkg::DIPC_CLS_EXC_RETURN: begin
				iss_n = dipc_pkg::DIPC_CNT_RTE_ISSUE; // RQ6
				br_n  = dipc_pkg::DIPC_CNT_RTE_BRANCH;
			end
			dipc_pkg::DIPC_CLS_SOFT_TRAP: begin
				iss_n = dipc_pkg::DIPC_CNT_TRAP_ISSUE; // RQ7
				ext_n = dipc_pkg::DIPC_CNT_TRAP_EXTRA;
				br_n  = dipc_pkg::DIPC_CNT_TRAP_BRANCH;
			end
			dipc_pkg::DIPC_CLS_SLEEP: begin
				iss_n = dipc_pkg::DIPC_CNT_SLEEP; // RQ8
			end
			dipc_pkg::DIPC_CLS_GBR_RMW: begin
				iss_n = dipc_pkg::DIPC_CNT_GBR_RMW; // RQ11
			end
			dipc_pkg::DIPC_CLS_TEST_SET: begin
				iss_n = dipc_pkg::DIPC_CNT_TEST_SET; // RQ11
			end
			dipc_pkg::DIPC_CLS_ICACHE_BLOCK_INVALIDATE: begin
				iss_n = dipc_pkg::DIPC_CNT_ICACHE_BLOCK_INVALIDATE_ISSUE; // RQ12
				ext_n = dipc_pkg::DIPC_CNT_CACHE_EXTRA;
				br_n  = dipc_pkg::DIPC_CNT_CACHE_BR;
			end
			dipc_pkg::DIPC_CLS_INSTRUCTION_BLOCK_PREFETCH: begin
				iss_n = dipc_pkg::DIPC_CNT_INSTRUCTION_BLOCK_PREFETCH_ISSUE; // RQ12
				ext_n = dipc_pkg::DIPC_CNT_CACHE_EXTRA;
				br_n  = dipc_pkg::DIPC_CNT_CACHE_BR;
			end
			dipc_pkg::DIPC_CLS_UNALIGNED: begin
				iss_n = dipc_pkg::DIPC_CNT_UNALIGNED; // RQ13
			end
			dipc_pkg::DIPC_CLS_LDC_SR_REG: begin
				iss_n = dipc_pkg::DIPC_CNT_LDC_SR_REG; // RQ14
				br_n  = dipc_pkg::DIPC_CNT_SR_BRANCH;
			end
			dipc_pkg::DIPC_CLS_LDC_SR_MEM: begin
				iss_n = dipc_pkg::DIPC_CNT_LDC_SR_MEM; // RQ14
				br_n  = dipc_pkg::DIPC_CNT_SR_BRANCH;
			end
			dipc_pkg::DIPC_CLS_LDC_DBR_SGR: begin
				iss_n = dipc_pkg::DIPC_CNT_LDC_CTRL; // RQ15
			end
			dipc_pkg::DIPC_CLS_MAC: begin
				iss_n = dipc_pkg::DIPC_CNT_MAC; // RQ18
			end
			default: begin
				iss_n = dipc_pkg::DIPC_CNT_ONE;
			end
		endcase
	end

	// ********************************************
	// Pipe occupancy
	// ********************************************
	always_comb begin
		uses_int = 1'b0;
		uses_ls  = 1'b0;
		if (lead_class == dipc_pkg::DIPC_CLS_STC_SR) begin
			uses_int = 1'b1; // RQ16
			uses_ls  = 1'b1;
		end else if (lead_group == dipc_pkg::DIPC_GRP_INTEGER_EXEC) begin
			uses_int = 1'b1; // RQ9
		end else if (lead_group == dipc_pkg::DIPC_GRP_LOAD_STORE) begin
			uses_ls = 1'b1;
		end else if (lead_group == dipc_pkg::DIPC_GRP_MOVE_TYPE) begin
			// A move goes wherever the partner leaves room. RQ10
			if (issue_follow && follow_group == dipc_pkg::DIPC_GRP_INTEGER_EXEC) begin
				uses_ls = 1'b1;
			end else begin
				uses_int = 1'b1;
			end
		end
	end

	// ********************************************
	// Sequencer
	// ********************************************
	always_comb begin
		next_r = r;
		next_r.stages = {r.stages[6:0], lead_go}; // RQ2
		next_r.int_busy = lead_go && (uses_int ||
			(issue_follow && follow_group == dipc_pkg::DIPC_GRP_INTEGER_EXEC));
		next_r.ls_busy = lead_go && (uses_ls ||
			(issue_follow && follow_group == dipc_pkg::DIPC_GRP_LOAD_STORE));
		if (r.pr_wait) begin
			next_r.pr_cnt = r.pr_cnt + 2'h1;
			if (r.pr_cnt == dipc_pkg::DIPC_PR_E3_DELAY) begin
				next_r.pr_wait = 1'b0;
			end
		end
		if (lead_go && lead_pr_set) begin
			next_r.pr_wait = 1'b1; // RQ17
			next_r.pr_cnt  = 2'h0;
		end
		case (r.state)
			dipc_pkg::DIPC_ST_RUN: begin
				if (lead_go) begin
					next_r.extra  = ext_n;
					next_r.branch = br_n;
					if (iss_n > dipc_pkg::DIPC_CNT_ONE) begin
						next_r.cnt   = iss_n - dipc_pkg::DIPC_CNT_ONE;
						next_r.state = dipc_pkg::DIPC_ST_ISSUE;
					end else if (ext_n != dipc_pkg::DIPC_CNT_ZERO) begin
						next_r.cnt   = ext_n;
						next_r.state = dipc_pkg::DIPC_ST_EXTRA;
					end else if (br_n != dipc_pkg::DIPC_CNT_ZERO) begin
						next_r.cnt   = br_n;
						next_r.state = dipc_pkg::DIPC_ST_BRANCH;
					end
				end
			end
			dipc_pkg::DIPC_ST_ISSUE: begin
				next_r.cnt = r.cnt - dipc_pkg::DIPC_CNT_ONE;
				if (r.cnt == dipc_pkg::DIPC_CNT_ONE) begin
					if (r.extra != dipc_pkg::DIPC_CNT_ZERO) begin
						next_r.cnt   = r.extra;
						next_r.state = dipc_pkg::DIPC_ST_EXTRA;
					end else if (r.branch != dipc_pkg::DIPC_CNT_ZERO) begin
						next_r.cnt   = r.branch;
						next_r.state = dipc_pkg::DIPC_ST_BRANCH;
					end else begin
						next_r.state = dipc_pkg::DIPC_ST_RUN;
					end
				end
			end
			dipc_pkg::DIPC_ST_EXTRA: begin
				next_r.cnt = r.cnt - dipc_pkg::DIPC_CNT_ONE;
				if (r.cnt == dipc_pkg::DIPC_CNT_ONE) begin
					next_r.cnt   = r.branch;
					next_r.state = dipc_pkg::DIPC_ST_BRANCH;
				end
			end
			dipc_pkg::DIPC_ST_BRANCH: begin
				next_r.cnt = r.cnt - dipc_pkg::DIPC_CNT_ONE;
				if (r.cnt == dipc_pkg::DIPC_CNT_ONE) begin
					next_r.state = dipc_pkg::DIPC_ST_RUN;
				end
			end
			default: begin
				next_r.state = dipc_pkg::DIPC_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r <= '{state: dipc_pkg::DIPC_ST_RUN, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// ********************************************
	// Outputs
	// ********************************************
	// Issue strobes are combinational so a stalled pair costs no extra cycle.
	assign issue_lead    = lead_go;
	assign issue_follow  = can_pair; // RQ24
	assign id_locked     = r.state != dipc_pkg::DIPC_ST_RUN ||
		(lead_valid && lead_conflict); // RQ25
	assign pipe_int_busy = r.int_busy;
	assign pipe_ls_busy  = r.ls_busy;
	assign stage_valid   = r.stages;
	// Last cycle of the wait is the delay slot's E3; reads there see the new value.
	assign pr_bypass     = r.pr_wait && follow_pr_read; // RQ17

	// ********************************************
	// Checks
	// ********************************************
	property p_page;
		@(posedge clk_sys) disable iff (!rst_n)
		issue_follow |-> same_page;
	endproperty
	a_page: assert property (p_page) else $error("pair crosses page"); // RQ20

	property p_excl;
		@(posedge clk_sys) disable iff (!rst_n)
		(lead_group == dipc_pkg::DIPC_GRP_EXCLUSIVE) |-> !issue_follow;
	endproperty
	a_excl: assert property (p_excl) else $error("exclusive paired"); // RQ23

	property p_conf;
		@(posedge clk_sys) disable iff (!rst_n)
		(lead_valid && lead_conflict) |-> (!issue_lead && id_locked);
	endproperty
	a_conf: assert property (p_conf) else $error("conflict not locked"); // RQ25

	property p_fconf;
		@(posedge clk_sys) disable iff (!rst_n)
		follow_conflict |-> !issue_follow;
	endproperty
	a_fconf: assert property (p_fconf) else $error("follower conflict paired"); // RQ21

	property p_rte;
		@(posedge clk_sys) disable iff (!rst_n)
		(issue_lead && lead_class == dipc_pkg::DIPC_CLS_EXC_RETURN) |=>
			id_locked [*5] ##1 !id_locked;
	endproperty
	a_rte: assert property (p_rte) else $error("exception return timing"); // RQ6

	property p_breg;
		@(posedge clk_sys) disable iff (!rst_n)
		(issue_lead && lead_class == dipc_pkg::DIPC_CLS_BRANCH_REG) |=>
			id_locked [*4] ##1 !id_locked;
	endproperty
	a_breg: assert property (p_breg) else $error("register branch timing"); // RQ4

	property p_trap;
		@(posedge clk_sys) disable iff (!rst_n)
		(issue_lead && lead_class == dipc_pkg::DIPC_CLS_SOFT_TRAP) |=>
			##13 id_locked ##1 !id_locked;
	endproperty
	a_trap: assert property (p_trap) else $error("trap timing"); // RQ7

	property p_mac;
		@(posedge clk_sys) disable iff (!rst_n)
		(issue_lead && lead_class == dipc_pkg::DIPC_CLS_MAC) |=>
			id_locked ##1 !id_locked;
	endproperty
	a_mac: assert property (p_mac) else $error("multiply-accumulate timing"); // RQ18

	property p_stage;
		@(posedge clk_sys) disable iff (!rst_n)
		issue_lead |-> ##8 stage_valid[7];
	endproperty
	a_stage: assert property (p_stage) else $error("stage walk lost"); // RQ2

	property p_stc;
		@(posedge clk_sys) disable iff (!rst_n)
		(issue_lead && lead_class == dipc_pkg::DIPC_CLS_STC_SR) |=>
			(pipe_int_busy && pipe_ls_busy);
	endproperty
	a_stc: assert property (p_stc) else $error("status store pipes"); // RQ16

	c_pair:  cover property (@(posedge clk_sys) issue_follow);
	c_trap:  cover property (@(posedge clk_sys)
		issue_lead && lead_class == dipc_pkg::DIPC_CLS_SOFT_TRAP);
	c_stall: cover property (@(posedge clk_sys) lead_valid && lead_conflict);
	c_prbyp: cover property (@(posedge clk_sys) pr_bypass);

endmodule

`default_nettype wire

// File: dv/dipc_fetch_model.sv
// Fetch and memory side model for the dual-issue pipeline control block.
// Assumes the bench loads one instruction pair at a time through load.
`timescale 1ns/1ps
`default_nettype none

module dipc_fetch_model (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire logic                  load,
	input  wire logic [31:0]           addr,
	input  wire dipc_pkg::dipc_group_t grp_a,
	input  wire dipc_pkg::dipc_group_t grp_b,
	input  wire dipc_pkg::dipc_class_t cls,
	input  wire logic [3:0]            ctl,
	input  wire logic [3:0]            hold,
	input  wire logic                  issue_lead,
	input  wire logic                  issue_follow,
	output logic                       lead_valid,
	output logic [31:0]                lead_addr,
	output dipc_pkg::dipc_group_t      lead_group,
	output dipc_pkg::dipc_class_t      lead_class,
	output logic                       lead_conflict,
	output logic                       lead_prefetched,
	output logic                       lead_pr_set,
	output logic                       follow_valid,
	output logic [31:0]                follow_addr,
	output dipc_pkg::dipc_group_t      follow_group,
	output logic                       follow_conflict,
	output logic                       follow_pr_read
);
	// ********************************************
	// Pair holding and producer latency
	// ********************************************
	logic [3:0] wait_n;

	// The producer result is late for hold cycles after the pair arrives.
	assign lead_conflict = lead_valid && (wait_n != 4'h0);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lead_valid   <= 1'b0;
			follow_valid <= 1'b0;
			wait_n       <= 4'h0;
			lead_addr    <= 32'h0000_0000;
			follow_addr  <= 32'h0000_0000;
			lead_group   <= dipc_pkg::DIPC_GRP_MOVE_TYPE;
			follow_group <= dipc_pkg::DIPC_GRP_MOVE_TYPE;
			lead_class   <= dipc_pkg::DIPC_CLS_SIMPLE;
			{lead_prefetched, lead_pr_set, follow_pr_read, follow_conflict} <= 4'h0;
		end else if (load) begin
			lead_valid   <= 1'b1;
			follow_valid <= 1'b1;
			lead_addr    <= addr;
			follow_addr  <= addr + 32'h0000_0002;
			lead_group   <= grp_a;
			follow_group <= grp_b;
			lead_class   <= cls;
			wait_n       <= hold;
			{lead_prefetched, lead_pr_set, follow_pr_read, follow_conflict} <= ctl;
		end else begin
			if (wait_n != 4'h0) begin
				wait_n <= wait_n - 4'h1;
			end
			if (issue_lead && (issue_follow || !follow_valid)) begin
				// Released address lines toggle so stale values never look valid.
				lead_valid   <= 1'b0;
				follow_valid <= 1'b0;
				lead_addr    <= ~lead_addr;
				follow_addr  <= ~follow_addr;
			end else if (issue_lead) begin
				// A refused follower comes back alone as the next lead.
				lead_addr    <= follow_addr;
				lead_group   <= follow_group;
				lead_class   <= dipc_pkg::DIPC_CLS_SIMPLE;
				lead_pr_set  <= 1'b0;
				follow_valid <= 1'b0;
				follow_addr  <= ~follow_addr;
			end
		end
	end
endmodule

`default_nettype wire

// File: dv/dual_issue_pipeline_control_tb.sv
// Self-checking bench for the dual-issue pipeline control block.
// Assumes the fetch model feeds the block; comb outputs are read at negedge.
`timescale 1ns/1ps
`default_nettype none

module dual_issue_pipeline_control_tb;
	logic                  clk_sys, rst_n, load;
	logic [31:0]           addr;
	dipc_pkg::dipc_group_t grp_a, grp_b, lead_group, follow_group;
	dipc_pkg::dipc_class_t cls, lead_class;
	logic [3:0]            ctl, hold;
	logic [31:0]           lead_addr, follow_addr;
	logic                  lead_valid, lead_conflict, lead_prefetched, lead_pr_set;
	logic                  follow_valid, follow_conflict, follow_pr_read;
	logic                  issue_lead, issue_follow, id_locked;
	logic                  pipe_int_busy, pipe_ls_busy, pr_bypass;
	logic [7:0]            stage_valid;
	int                    miscompares, tests_run;

	dipc_fetch_model u_fetch (.clk_sys, .rst_n, .load, .addr, .grp_a, .grp_b, .cls, .ctl,
		.hold, .issue_lead, .issue_follow, .lead_valid, .lead_addr, .lead_group,
		.lead_class, .lead_conflict, .lead_prefetched, .lead_pr_set, .follow_valid,
		.follow_addr, .follow_group, .follow_conflict, .follow_pr_read);

	dipc_issue_ctrl #(.ADDR_W(32)) dut (.clk_sys, .rst_n, .lead_valid, .lead_addr,
		.lead_group, .lead_class, .lead_conflict, .lead_prefetched, .lead_pr_set,
		.follow_valid, .follow_addr, .follow_group, .follow_conflict, .follow_pr_read,
		.issue_lead, .issue_follow, .id_locked, .pipe_int_busy, .pipe_ls_busy,
		.stage_valid, .pr_bypass);

	// ********************************************
	// Shared tasks
	// ********************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	// Locked cycles after issue: issue count less one, plus extra and branch cycles.
	function automatic int lock_of(input dipc_pkg::dipc_class_t c, input logic p);
		case (c)
			dipc_pkg::DIPC_CLS_BRANCH_DISP: return p ? 0 : 3;
			dipc_pkg::DIPC_CLS_BRANCH_REG:  return 4;
			dipc_pkg::DIPC_CLS_SUB_RETURN:  return p ? 0 : 4;
			dipc_pkg::DIPC_CLS_EXC_RETURN:  return 3 + 2;
			dipc_pkg::DIPC_CLS_SOFT_TRAP:   return 7 + 5 + 2;
			dipc_pkg::DIPC_CLS_SLEEP:       return 1;
			dipc_pkg::DIPC_CLS_GBR_RMW:     return 2;
			dipc_pkg::DIPC_CLS_TEST_SET:    return 3;
			dipc_pkg::DIPC_CLS_ICACHE_BLOCK_INVALIDATE:        return 7 + 5 + 4;
			dipc_pkg::DIPC_CLS_INSTRUCTION_BLOCK_PREFETCH:       return 4 + 5 + 4;
			dipc_pkg::DIPC_CLS_UNALIGNED:   return 1;
			dipc_pkg::DIPC_CLS_LDC_SR_REG:  return 3 + 4;
			dipc_pkg::DIPC_CLS_LDC_SR_MEM:  return 5 + 4;
			dipc_pkg::DIPC_CLS_LDC_DBR_SGR: return 3;
			dipc_pkg::DIPC_CLS_MAC:         return 1;
			default:                        return 0;
		endcase
	endfunction

	// Offer one pair, wait for issue, then measure the decode lock.
	task automatic run(input logic [31:0] ad, input dipc_pkg::dipc_group_t ga,
		input dipc_pkg::dipc_group_t gb, input dipc_pkg::dipc_class_t c,
		input logic [3:0] ct, input logic [3:0] h, input logic ef, input int el);
		int n;
		int k;
		@(posedge clk_sys);
		load  <= 1'b1;
		addr  <= ad;
		grp_a <= ga;
		grp_b <= gb;
		cls   <= c;
		ctl   <= ct;
		hold  <= h;
		@(posedge clk_sys);
		load <= 1'b0;
		for (n = 0; n < 40; n++) begin
			@(negedge clk_sys);
			if (issue_lead === 1'b1) break;
			if (n < h) chk(id_locked === 1'b1, "decode not locked on conflict");
		end
		chk(n === int'(h), "issue wait wrong");
		if (n == 40) report_and_stop();
		chk(issue_follow === ef, "pairing decision wrong");
		for (k = 0; k < 20; k++) begin
			@(negedge clk_sys);
			if (id_locked !== 1'b1) break;
		end
		chk(k === el, "locked cycle count wrong");
		if (!ef) chk(issue_lead === 1'b1, "held follower not issued alone");
	endtask

	// ********************************************
	// Scenarios
	// ********************************************
	task automatic t_stage();
		run(32'h0000_1000, dipc_pkg::DIPC_GRP_INTEGER_EXEC, dipc_pkg::DIPC_GRP_BRANCH,
			dipc_pkg::DIPC_CLS_SIMPLE, 4'h0, 4'h0, 1'b1, 0);
		for (int k = 0; k < 8; k++) begin
			chk(stage_valid === (8'h01 << k), "stage walk wrong");
			@(negedge clk_sys);
		end
		chk(stage_valid === 8'h00, "stage walk not empty");
	endtask

	task automatic t_classes();
		dipc_pkg::dipc_group_t g;
		for (int c = 0; c < 17; c++) begin
			for (int p = 0; p < 2; p++) begin
				g = (c >= 1 && c <= 3) ? dipc_pkg::DIPC_GRP_BRANCH :
					(c == 0) ? dipc_pkg::DIPC_GRP_INTEGER_EXEC : dipc_pkg::DIPC_GRP_EXCLUSIVE;
				run(32'h0000_2000, g, dipc_pkg::DIPC_GRP_MOVE_TYPE, dipc_pkg::dipc_class_t'(c),
					{p[0], 3'h0}, 4'h0, c == 0 || ((c == 1 || c == 3) && p == 1),
					lock_of(dipc_pkg::dipc_class_t'(c), p[0]));
			end
		end
	endtask

	task automatic t_pairs();
		logic ok;
		for (int a = 0; a < 6; a++) begin
			for (int b = 0; b < 6; b++) begin
				ok = a != 5 && b != 5 && (a == 1 || b == 1 || a != b);
				run(32'h0000_3000, dipc_pkg::dipc_group_t'(a), dipc_pkg::dipc_group_t'(b),
					dipc_pkg::DIPC_CLS_SIMPLE, 4'h0, 4'h0, ok, 0);
			end
		end
	endtask

	task automatic t_page_conflict();
		run(32'h0000_03FC, dipc_pkg::DIPC_GRP_INTEGER_EXEC, dipc_pkg::DIPC_GRP_MOVE_TYPE,
			dipc_pkg::DIPC_CLS_SIMPLE, 4'h0, 4'h0, 1'b1, 0);
		run(32'h0000_03FE, dipc_pkg::DIPC_GRP_INTEGER_EXEC, dipc_pkg::DIPC_GRP_MOVE_TYPE,
			dipc_pkg::DIPC_CLS_SIMPLE, 4'h0, 4'h0, 1'b0, 0);
		run(32'h0000_4000, dipc_pkg::DIPC_GRP_INTEGER_EXEC, dipc_pkg::DIPC_GRP_MOVE_TYPE,
			dipc_pkg::DIPC_CLS_SIMPLE, 4'h0, 4'h3, 1'b1, 0);
		run(32'h0000_4000, dipc_pkg::DIPC_GRP_INTEGER_EXEC, dipc_pkg::DIPC_GRP_MOVE_TYPE,
			dipc_pkg::DIPC_CLS_SIMPLE, 4'h1, 4'h0, 1'b0, 0);
	endtask

	task automatic t_pipes();
		run(32'h0000_5000, dipc_pkg::DIPC_GRP_INTEGER_EXEC, dipc_pkg::DIPC_GRP_INTEGER_EXEC,
			dipc_pkg::DIPC_CLS_SIMPLE, 4'h0, 4'h0, 1'b0, 0);
		chk(pipe_int_busy === 1'b1 && pipe_ls_busy === 1'b0, "integer pipe use");
		run(32'h0000_5000, dipc_pkg::DIPC_GRP_MOVE_TYPE, dipc_pkg::DIPC_GRP_INTEGER_EXEC,
			dipc_pkg::DIPC_CLS_SIMPLE, 4'h0, 4'h0, 1'b1, 0);
		chk(pipe_int_busy === 1'b1 && pipe_ls_busy === 1'b1, "move to free pipe");
		run(32'h0000_5000, dipc_pkg::DIPC_GRP_EXCLUSIVE, dipc_pkg::DIPC_GRP_EXCLUSIVE,
			dipc_pkg::DIPC_CLS_STC_SR, 4'h0, 4'h0, 1'b0, 0);
		chk(pipe_int_busy === 1'b1 && pipe_ls_busy === 1'b1, "status store pipes");
	endtask

	task automatic t_pr();
		run(32'h0000_6000, dipc_pkg::DIPC_GRP_BRANCH, dipc_pkg::DIPC_GRP_INTEGER_EXEC,
			dipc_pkg::DIPC_CLS_BRANCH_DISP, 4'he, 4'h0, 1'b1, 0);
		chk(pr_bypass === 1'b1, "delay slot misses new return value");
		repeat (5) @(negedge clk_sys);
		chk(pr_bypass === 1'b0, "bypass outlives update");
	endtask

	// ********************************************
	// Clock, reset and main sequence
	// ********************************************
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	initial begin
		miscompares = 0;
		tests_run   = 0;
		rst_n = 1'b0;
		load  = 1'b0;
		addr  = 32'h0000_0000;
		grp_a = dipc_pkg::DIPC_GRP_MOVE_TYPE;
		grp_b = dipc_pkg::DIPC_GRP_MOVE_TYPE;
		cls   = dipc_pkg::DIPC_CLS_SIMPLE;
		ctl   = 4'h0;
		hold  = 4'h0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_stage();
		t_classes();
		t_pairs();
		t_page_conflict();
		t_pipes();
		t_pr();
		report_and_stop();
	end
endmodule

`default_nettype wire
